//--- bench/pss_status_flags_assertions.sv
// Purpose : Port-level checks on the status flag block.
// Assumes : The flag image refreshes on the edge after scan_end.
// Notes   : Inputs are held stable around scan_end by the bench.
`timescale 1ns/10ps
module pss_status_flags_assertions
   import pss_pkg::*;
(
   input wire logic               mclk,
   input wire logic               srst,
   input wire logic               scan_end,
   input wire logic [NUM_ERR-1:0] err_in,
   input wire logic               battery_low_in,
   input wire logic               supply_low_in,
   input wire logic               error_summary_flag,
   input wire logic               battery_low_live_flag,
   input wire logic               battery_low_latched_flag,
   input wire logic               momentary_interrupt_pulse,
   input wire logic               power_interrupt_flag,
   input wire logic               serial_error_ch2_flag,
   input wire logic               run_monitor_flag
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);
   wire logic [6:0] img = {error_summary_flag, battery_low_live_flag,
      battery_low_latched_flag, momentary_interrupt_pulse,
      power_interrupt_flag, serial_error_ch2_flag, run_monitor_flag};
   // ==========================================================
   // Supply drop seen, then a quiet gap, then a boundary
   sequence s_drop;
      $rose(supply_low_in) && !scan_end ##1 !scan_end [*4]
         ##1 scan_end && supply_low_in;
   endsequence
   a_image_on_scan: assert property (
      $changed(img) && !$past(srst) |-> $past(scan_end))
      else $error("Flag image moved off a scan boundary");
   a_err_summary: assert property (
      scan_end && $stable(err_in) |=> error_summary_flag == |$past(err_in))
      else $error("Error summary disagrees with error inputs");
   a_bat_live: assert property (
      scan_end && $stable(battery_low_in)
         |=> battery_low_live_flag == $past(battery_low_in))
      else $error("Live battery flag disagrees with detector");
   a_bat_latch_set: assert property (
      scan_end && battery_low_in && $past(battery_low_in)
         |=> battery_low_latched_flag)
      else $error("Battery latch not set on detection");
   a_pulse_set: assert property (
      s_drop |=> momentary_interrupt_pulse && power_interrupt_flag)
      else $error("Interruption not flagged at next boundary");
   a_pulse_one_scan: assert property (
      momentary_interrupt_pulse && scan_end && $stable(supply_low_in)
         |=> !momentary_interrupt_pulse)
      else $error("Momentary pulse outlived one scan");
   a_run_stop: assert property (
      $fell(run_monitor_flag) |-> !power_interrupt_flag && supply_low_in)
      else $error("Run stopped without an interruption timeout");
   a_ser2_sticky: assert property (
      serial_error_ch2_flag |=> serial_error_ch2_flag)
      else $error("Serial error flag cleared without power-up");
endmodule

bind pss_status_flags pss_status_flags_assertions u_chk (
   .mclk, .srst, .scan_end, .err_in, .battery_low_in, .supply_low_in,
   .error_summary_flag, .battery_low_live_flag, .battery_low_latched_flag,
   .momentary_interrupt_pulse, .power_interrupt_flag,
   .serial_error_ch2_flag, .run_monitor_flag);

//--- bench/pss_status_flags_tb.sv
// Purpose : Self-checking bench for the status flag block.
// Assumes : TICK_CYC of 4 makes one limit unit 40 ns.
// Notes   : Flags are checked at the ports and through FLAGS.
`timescale 1ns/10ps
module pss_status_flags_tb
   import pss_pkg::*;
();
   typedef struct packed {
      logic [6:0]  e;
      logic        b, a, u, p;
      logic [10:0] x;
   } pss_row_t;
   localparam int TICK = 4;
   logic mclk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, scan_end = 1'b0, battery_low_in = 1'b0;
   logic supply_low_in = 1'b0, aux_supply_fail_in = 1'b0;
   logic serial_err_ch2_in = 1'b0, special_block_err_in = 1'b0;
   logic usb_err_in = 1'b0, special_param_err_in = 1'b0, pready, pslverr;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [NUM_ERR-1:0] err_in = '0;
   logic [DET_W-1:0] serial_err_ch2_code = '0, special_block_err_code = '0;
   logic error_summary_flag, battery_low_live_flag, battery_low_latched_flag;
   logic momentary_interrupt_pulse, power_interrupt_flag, aux_supply_fail_flag;
   logic serial_error_ch2_flag, special_block_error_flag, usb_error_flag;
   logic special_param_error_flag, run_monitor_flag, irq, se;
   logic [NUM_OUT-1:0] user_interrupt_cmd_out, clear_signal_spec_enable_out;
   logic [NUM_OUT*SEL_W-1:0] clear_signal_select;
   logic [10:0] img;
   int err_total = 0, tests_run = 0;
   pss_row_t rows [4] = '{22'h000000, 22'h00d107, 22'h202a25, 22'h000004};
   assign img = {run_monitor_flag, special_param_error_flag, usb_error_flag,
      special_block_error_flag, serial_error_ch2_flag, aux_supply_fail_flag,
      power_interrupt_flag, momentary_interrupt_pulse,
      battery_low_latched_flag, battery_low_live_flag, error_summary_flag};

   pss_status_flags #(.TICK_CYC(TICK)) u_dut (
      .mclk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .scan_end, .err_in, .battery_low_in,
      .supply_low_in, .aux_supply_fail_in, .serial_err_ch2_in,
      .serial_err_ch2_code, .special_block_err_in, .special_block_err_code,
      .usb_err_in, .special_param_err_in, .error_summary_flag,
      .battery_low_live_flag, .battery_low_latched_flag,
      .momentary_interrupt_pulse, .power_interrupt_flag,
      .aux_supply_fail_flag, .serial_error_ch2_flag,
      .special_block_error_flag, .usb_error_flag, .special_param_error_flag,
      .run_monitor_flag, .user_interrupt_cmd_out,
      .clear_signal_spec_enable_out, .clear_signal_select, .irq);

   initial begin
      forever #5 mclk = ~mclk;
   end
   // ==========================================================
   // Shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Quiet gap first so every input is stable at the boundary
   task automatic scan();
      repeat (5) @(posedge mclk);
      scan_end <= 1'b1;
      @(posedge mclk);
      scan_end <= 1'b0;
      @(negedge mclk);
   endtask
   task automatic final_report();
      $display("tests_run %0d err_total %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge mclk);
      err_total++;
      final_report();
   end
   // ==========================================================
   // Main sequence
   initial begin
      repeat (12) @(posedge mclk);
      srst <= 1'b0;
      apb(1'b0, OFS_LIMIT, 32'h0);
      chk(rd, {16'h0, LIMIT_RST});
      apb(1'b0, 8'h40, 32'h0);
      chk(rd, 32'h0);
      chk(se, 1'b1);
      foreach (rows[i]) begin
         @(posedge mclk);
         err_in <= rows[i].e;
         battery_low_in <= rows[i].b;
         aux_supply_fail_in <= rows[i].a;
         usb_err_in <= rows[i].u;
         special_param_err_in <= rows[i].p;
         scan();
         chk(img, rows[i].x);
         apb(1'b0, OFS_FLAGS, 32'h0);
         chk(rd, rows[i].x);
      end
      for (int i = 0; i < NUM_ERR; i++) begin
         @(posedge mclk);
         err_in <= 7'h01 << i;
         scan();
         chk(error_summary_flag, 1'b1);
      end
      @(posedge mclk);
      err_in <= '0;
      apb(1'b1, OFS_CTRL, 32'h1);
      scan();
      chk(img[2:0], 3'h0);
      apb(1'b1, OFS_CTRL, 32'h2);
      scan();
      @(posedge mclk);
      supply_low_in <= 1'b1;
      scan();
      chk({img[3], img[4], img[10]}, 3'h7);
      scan();
      chk({img[3], img[4], img[10]}, 3'h3);
      @(posedge mclk);
      supply_low_in <= 1'b0;
      scan();
      chk({img[3], img[4], img[10]}, 3'h1);
      apb(1'b1, OFS_LIMIT, 32'h2);
      @(posedge mclk);
      supply_low_in <= 1'b1;
      scan();
      chk({img[3], img[4], img[10]}, 3'h7);
      repeat (8 * TICK) @(posedge mclk);
      scan();
      chk({img[3], img[4], img[10]}, 3'h0);
      @(posedge mclk);
      supply_low_in <= 1'b0;
      serial_err_ch2_in <= 1'b1;
      serial_err_ch2_code <= 16'h00a5;
      special_block_err_in <= 1'b1;
      special_block_err_code <= 16'h005a;
      scan();
      @(posedge mclk);
      serial_err_ch2_in <= 1'b0;
      special_block_err_in <= 1'b0;
      apb(1'b0, OFS_SER_DET, 32'h0);
      chk(rd, 32'h000000a5);
      apb(1'b0, OFS_BLK_DET, 32'h0);
      chk(rd, 32'h0000005a);
      scan();
      chk(img[7:6], 2'h3);
      chk(irq, 1'b0);
      apb(1'b1, OFS_INT_MASK, 32'h40);
      repeat (2) @(negedge mclk);
      chk(irq, 1'b1);
      apb(1'b0, OFS_INT_STAT, 32'h0);
      chk(rd[6], 1'b1);
      apb(1'b1, OFS_INT_STAT, 32'h40);
      repeat (2) @(negedge mclk);
      chk(irq, 1'b0);
      apb(1'b1, OFS_POS_CTRL, 32'h000000a5);
      apb(1'b1, OFS_CLR_SEL, 32'h04030201);
      @(negedge mclk);
      chk(user_interrupt_cmd_out, 4'h5);
      chk(clear_signal_spec_enable_out, 4'ha);
      chk(clear_signal_select, 32'h04030201);
      @(posedge mclk);
      srst <= 1'b1;
      repeat (2) @(posedge mclk);
      srst <= 1'b0;
      @(negedge mclk);
      chk(img, 11'h000);
      final_report();
   end
endmodule

//--- src/pss_pkg.sv
// Purpose : Constants and types for the system status flag block.
// Assumes : 100 MHz mclk, APB register access, 32-bit data.
// Notes   : Flag image and interrupt status share one bit layout.
package pss_pkg;

   // ===========================================================
   // Clock and timing
   localparam int CLK_PERIOD_NS   = 10;
   localparam int LIMIT_UNIT_NS   = 1000000;   // Limit counts in 1 ms
   localparam int LIMIT_UNIT_CYC  = LIMIT_UNIT_NS / CLK_PERIOD_NS;

   // ===========================================================
   // Register offsets (byte addresses)
   localparam logic [7:0] OFS_FLAGS    = 8'h00;
   localparam logic [7:0] OFS_INT_STAT = 8'h04;
   localparam logic [7:0] OFS_INT_MASK = 8'h08;
   localparam logic [7:0] OFS_LIMIT    = 8'h0c;
   localparam logic [7:0] OFS_SER_DET  = 8'h10;
   localparam logic [7:0] OFS_BLK_DET  = 8'h14;
   localparam logic [7:0] OFS_POS_CTRL = 8'h18;
   localparam logic [7:0] OFS_CLR_SEL  = 8'h1c;
   localparam logic [7:0] OFS_CTRL     = 8'h20;

   // ===========================================================
   // Flag image bit positions
   localparam int FLAG_W      = 11;
   localparam int F_ERR_SUM   = 0;
   localparam int F_BAT_LIVE  = 1;
   localparam int F_BAT_LATCH = 2;
   localparam int F_MOMENT    = 3;
   localparam int F_PWR_INT   = 4;
   localparam int F_AUX_FAIL  = 5;
   localparam int F_SER2      = 6;
   localparam int F_BLK       = 7;
   localparam int F_USB       = 8;
   localparam int F_PARAM     = 9;
   localparam int F_RUN       = 10;

   // CTRL register bits
   localparam int C_BAT_CLR   = 0;
   localparam int C_RUN_REQ   = 1;

   // ===========================================================
   // Widths and reset values
   localparam int DET_W       = 16;
   localparam int LIMIT_W     = 16;
   localparam int NUM_ERR     = 7;
   localparam int NUM_OUT     = 4;
   localparam int SEL_W       = 8;
   localparam logic [LIMIT_W-1:0] LIMIT_RST = 16'h000a;
   localparam logic [FLAG_W-1:0]  MASK_RST  = 11'h000;

   // Supply supervision states
   typedef enum logic [2:0] {
      PW_OK   = 3'b001,
      PW_LOW  = 3'b010,
      PW_STOP = 3'b100
   } pss_pw_t;

endpackage

//--- src/pss_status_flags.sv
// Purpose : System status and error flag logic with an APB register file.
// Assumes : All inputs synchronous to mclk; srst is the power-up reset.
// Notes   : Flags seen by the program change only on scan_end.
//
// What this block does
// [RL1] Error summary is set while any of seven error inputs is set.
// [RL2] Live battery-low flag follows the battery-low detector exactly.
// [RL3] Latched battery-low flag sets on detection and stays set until a CTRL clear write while the detector is low.
// [RL4] Momentary-interruption flag is high for exactly one scan per event.
// [RL5] Run continues while low-supply time stays within the limit register.
// [RL6] Interruption flag sets; past the limit it clears and run stops.
// [RL7] Supply-failure flag sets when the 24 V auxiliary supply fails.
// [RL8] Channel 2 serial error sets its flag and stores the detail.
// [RL9] Channel 2 serial error flag is cleared only by power-up.
// [RL10] Special block error sets its flag and provides the detail.
// [RL11] Program drives per-output interrupt commands to the positioning.
// [RL12] Program enables per-output clear signal with a selected output.
// [RL13] Flag image updates only at scan boundaries.
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/10ps
module pss_status_flags
   import pss_pkg::*;
#(
   parameter int TICK_CYC = LIMIT_UNIT_CYC
) (
   input  wire logic                      mclk,
   input  wire logic                      srst,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [7:0]                paddr,
   input  wire logic [31:0]               pwdata,
   output logic      [31:0]               prdata,
   output logic                           pready,
   output logic                           pslverr,
   input  wire logic                      scan_end,
   input  wire logic [NUM_ERR-1:0]        err_in,
   input  wire logic                      battery_low_in,
   input  wire logic                      supply_low_in,
   input  wire logic                      aux_supply_fail_in,
   input  wire logic                      serial_err_ch2_in,
   input  wire logic [DET_W-1:0]          serial_err_ch2_code,
   input  wire logic                      special_block_err_in,
   input  wire logic [DET_W-1:0]          special_block_err_code,
   input  wire logic                      usb_err_in,
   input  wire logic                      special_param_err_in,
   output logic                           error_summary_flag,
   output logic                           battery_low_live_flag,
   output logic                           battery_low_latched_flag,
   output logic                           momentary_interrupt_pulse,
   output logic                           power_interrupt_flag,
   output logic                           aux_supply_fail_flag,
   output logic                           serial_error_ch2_flag,
   output logic                           special_block_error_flag,
   output logic                           usb_error_flag,
   output logic                           special_param_error_flag,
   output logic                           run_monitor_flag,
   output logic      [NUM_OUT-1:0]        user_interrupt_cmd_out,
   output logic      [NUM_OUT-1:0]        clear_signal_spec_enable_out,
   output logic      [NUM_OUT*SEL_W-1:0]  clear_signal_select,
   output logic                           irq
);

   // ===========================================================
   // Elaboration checks
   localparam int BUS_W = 32;

   // A tick count below two leaves no room for the wrap compare
   if (TICK_CYC < 2) begin : g_chk
      $error("TICK_CYC must be at least 2");
   end
   if (NUM_ERR < 1) begin : g_chk_err
      $error("At least one error input feeds the summary");
   end
   if (FLAG_W > BUS_W) begin : g_chk_flag
      $error("Flag image must fit one bus word");
   end
   if (F_RUN >= FLAG_W || F_PARAM >= FLAG_W) begin : g_chk_bits
      $error("Flag bit positions must lie inside the image");
   end
   if (2 * NUM_OUT > BUS_W || NUM_OUT * SEL_W > BUS_W) begin : g_chk_out
      $error("Positioning fields must fit one bus word");
   end
   if (LIMIT_W > BUS_W || DET_W > BUS_W) begin : g_chk_word
      $error("Limit and detail registers must fit one bus word");
   end
   if (C_BAT_CLR == C_RUN_REQ) begin : g_chk_ctrl
      $error("Control bits must be distinct");
   end

   localparam int TW = $clog2(TICK_CYC);

   // ===========================================================
   // State
   typedef struct packed {
      logic [FLAG_W-1:0]        img;
      logic                     bat_latch;
      logic                     moment_pend;
      logic                     pwr_flag;
      logic                     ser_flag;
      logic                     blk_flag;
      logic                     run;
      pss_pw_t                  pw;
      logic [TW-1:0]            tick;
      logic [LIMIT_W:0]         ms_cnt;
      logic [DET_W-1:0]         ser_det;
      logic [DET_W-1:0]         blk_det;
      logic [LIMIT_W-1:0]       limit;
      logic [FLAG_W-1:0]        int_stat;
      logic [FLAG_W-1:0]        int_mask;
      logic [NUM_OUT-1:0]       cmd;
      logic [NUM_OUT-1:0]       clr_en;
      logic [NUM_OUT*SEL_W-1:0] clr_sel;
      logic [31:0]              rdata;
      logic                     ready;
      logic                     slverr;
      logic                     irq;
   } pss_state_t;

   pss_state_t q, d;

   logic              acc;
   logic              wr;
   logic [FLAG_W-1:0] live;
   logic [FLAG_W-1:0] events;
   logic              mapped;

   // ===========================================================
   // Next state
   always_comb begin
      d      = q;
      acc    = psel && penable && q.ready;
      wr     = acc && pwrite;
      mapped = 1'b0;
      events = '0;

      // ========================================================
      // Supply supervision; the limit is counted in whole units
      case (q.pw)
         PW_OK: begin
            if (supply_low_in) begin
               d.pw          = PW_LOW;
               d.pwr_flag    = 1'b1;                          // [RL6]
               d.moment_pend = 1'b1;                          // [RL4]
               d.tick        = '0;
               d.ms_cnt      = '0;
            end
         end
         PW_LOW: begin
            if (!supply_low_in) begin
               d.pw       = PW_OK;                            // [RL5]
               d.pwr_flag = 1'b0;
            // Stop once the count passes the limit, i.e. limit+1 units
            end else if (q.ms_cnt > {1'b0, q.limit}) begin
               d.pw       = PW_STOP;
               d.pwr_flag = 1'b0;                             // [RL6]
               d.run      = 1'b0;                             // [RL6]
            end else if (q.tick == TW'(TICK_CYC - 1)) begin
               d.tick   = '0;
               d.ms_cnt = q.ms_cnt + (LIMIT_W+1)'(1);
            end else begin
               d.tick = q.tick + TW'(1);
            end
         end
         PW_STOP: begin
            // Recovery re-arms supervision; run waits for software
            if (!supply_low_in) begin
               d.pw = PW_OK;
            end
         end
         default: begin
            d.pw = PW_OK;
         end
      endcase

      // ========================================================
      // Sticky captures; only power-up clears serial and block flags
      if (battery_low_in) begin
         d.bat_latch = 1'b1;                                  // [RL3]
      end
      if (serial_err_ch2_in) begin
         d.ser_flag = 1'b1;                                   // [RL8]
         d.ser_det  = serial_err_ch2_code;                    // [RL8]
      end
      if (special_block_err_in) begin
         d.blk_flag = 1'b1;                                   // [RL10]
         d.blk_det  = special_block_err_code;                 // [RL10]
      end

      // ========================================================
      // Live image as the program would see it now
      live              = '0;
      live[F_ERR_SUM]   = |err_in;                            // [RL1]
      live[F_BAT_LIVE]  = battery_low_in;                     // [RL2]
      live[F_BAT_LATCH] = q.bat_latch;
      live[F_MOMENT]    = q.moment_pend;
      live[F_PWR_INT]   = q.pwr_flag;
      live[F_AUX_FAIL]  = aux_supply_fail_in;                 // [RL7]
      live[F_SER2]      = q.ser_flag;
      live[F_BLK]       = q.blk_flag;
      live[F_USB]       = usb_err_in;
      live[F_PARAM]     = special_param_err_in;
      live[F_RUN]       = q.run;

      // ========================================================
      // Image refresh at scan end; a pulse pending then is shown once.
      // A drop on the boundary cycle itself keeps its pulse for later.
      if (scan_end) begin
         d.img = live;                                        // [RL13]
         if (!(q.pw == PW_OK && supply_low_in)) begin
            d.moment_pend = 1'b0;                             // [RL4]
         end
         // Interrupt status records rising image bits only
         events = live & ~q.img;
      end

      // ========================================================
      // APB: no wait state, data prepared during setup
      // Read data is frozen in setup, so a boundary cannot tear it
      d.ready  = psel && !penable && !q.ready;
      d.slverr = 1'b0;
      if (psel && !penable) begin
         d.rdata = '0;
         mapped  = 1'b1;
         case (paddr)
            OFS_FLAGS:    d.rdata[FLAG_W-1:0]     = q.img;
            OFS_INT_STAT: d.rdata[FLAG_W-1:0]     = q.int_stat;
            OFS_INT_MASK: d.rdata[FLAG_W-1:0]     = q.int_mask;
            OFS_LIMIT:    d.rdata[LIMIT_W-1:0]    = q.limit;
            OFS_SER_DET:  d.rdata[DET_W-1:0]      = q.ser_det;
            OFS_BLK_DET:  d.rdata[DET_W-1:0]      = q.blk_det;
            OFS_POS_CTRL: d.rdata[2*NUM_OUT-1:0]  = {q.clr_en, q.cmd};
            OFS_CLR_SEL:  d.rdata[NUM_OUT*SEL_W-1:0] = q.clr_sel;
            OFS_CTRL:     d.rdata[C_RUN_REQ]      = q.run;
            default:      mapped                  = 1'b0;
         endcase
         d.slverr = !mapped;
      end

      // ========================================================
      // Register writes
      // Set wins over a write-one clear in the same cycle
      d.int_stat = q.int_stat | events;
      if (wr) begin
         case (paddr)
            OFS_INT_STAT: begin
               d.int_stat = (q.int_stat & ~pwdata[FLAG_W-1:0]) | events;
            end
            OFS_INT_MASK: d.int_mask = pwdata[FLAG_W-1:0];
            OFS_LIMIT:    d.limit    = pwdata[LIMIT_W-1:0];
            OFS_POS_CTRL: begin
               d.cmd    = pwdata[NUM_OUT-1:0];                // [RL11]
               d.clr_en = pwdata[2*NUM_OUT-1:NUM_OUT];        // [RL12]
            end
            OFS_CLR_SEL:  d.clr_sel = pwdata[NUM_OUT*SEL_W-1:0]; // [RL12]
            OFS_CTRL: begin
               if (pwdata[C_BAT_CLR] && !battery_low_in) begin
                  d.bat_latch = 1'b0;                         // [RL3]
               end
               if (pwdata[C_RUN_REQ] && q.pw == PW_OK) begin
                  d.run = 1'b1;
               end
            end
            default: begin
            end
         endcase
      end

      // From next state, so irq follows a mask write on the same edge
      d.irq = |(d.int_stat & d.int_mask);
   end

   // ===========================================================
   // Registers; reset is the power-up event
   always_ff @(posedge mclk) begin
      if (srst) begin
         q          <= '0;
         q.pw       <= PW_OK;
         // Named apart so the power-up clear of this flag stays explicit
         q.ser_flag <= 1'b0;                                  // [RL9]
         q.limit    <= LIMIT_RST;
         q.int_mask <= MASK_RST;
      end else begin
         q <= d;
      end
   end

   // ===========================================================
   // Outputs
   // Flag outputs are image bits, never live values
   assign prdata                       = q.rdata;
   assign pready                       = q.ready;
   assign pslverr                      = q.slverr;
   assign error_summary_flag           = q.img[F_ERR_SUM];
   assign battery_low_live_flag        = q.img[F_BAT_LIVE];
   assign battery_low_latched_flag     = q.img[F_BAT_LATCH];
   assign momentary_interrupt_pulse    = q.img[F_MOMENT];
   assign power_interrupt_flag         = q.img[F_PWR_INT];
   assign aux_supply_fail_flag         = q.img[F_AUX_FAIL];
   assign serial_error_ch2_flag        = q.img[F_SER2];
   assign special_block_error_flag     = q.img[F_BLK];
   assign usb_error_flag               = q.img[F_USB];
   assign special_param_error_flag     = q.img[F_PARAM];
   assign run_monitor_flag             = q.img[F_RUN];
   assign user_interrupt_cmd_out       = q.cmd;
   assign clear_signal_spec_enable_out = q.clr_en;
   assign clear_signal_select          = q.clr_sel;
   assign irq                          = q.irq;

endmodule
